// File: src/tcc_defs.svh
// constants for the timer counter with capture and compare
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// register offsets (word index on the plain register port)
`define ADDR_STATUS_CONTROL  6'h00
`define ADDR_COUNTER_VALUE   6'h01
`define ADDR_COUNTER_MODULO  6'h02
`define ADDR_COUNTER_INITIAL 6'h03
`define ADDR_MODE            6'h04
`define ADDR_CH_CTRL_BASE    6'h08
`define ADDR_CH_VALUE_BASE   6'h10
`define ADDR_FILTER          6'h18
// status_control fields
`define SC_PS_LSB     0
`define SC_CLOCK_SOURCE_SELECT_LSB   3
`define SC_CENTER_ALIGN_SELECT_BIT  5
`define SC_TOF_BIT    7
`define SC_OVERFLOW_SKIP_COUNT_LSB 8
// mode register fields
`define MODE_EXTENDED_FEATURES_ENABLE_BIT  0
`define MODE_DEBUG_BIT  1
`define MODE_SYNC_BIT   2
// channel control fields
`define CH_ELSA_BIT 2
`define CH_ELSB_BIT 3
`define CH_MSA_BIT  4
`define CH_MSB_BIT  5
`define CH_IE_BIT   6
`define CH_FLAG_BIT 7
// clock source encodings
`define CLOCK_SOURCE_SELECT_NONE  2'h0
`define CLOCK_SOURCE_SELECT_SYS   2'h1
`define CLOCK_SOURCE_SELECT_FIXED 2'h2
`define CLOCK_SOURCE_SELECT_EXT   2'h3
`define FREE_MAX   16'hFFFF
`define CNT_ZERO   16'h0000
`define CNT_ONE    16'h0001
`define FILT_DIV   2'h3
`endif

// File: src/tcc_pkg.sv
// types for the timer counter with capture and compare
package tcc_pkg;
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  typedef struct packed {
    logic       flag;
    logic       ie;
    logic [1:0] ms;
    logic [1:0] els;
  } ch_cfg_t;
endpackage : tcc_pkg

// File: src/timer_counter_capture_compare.sv
// timer counter with clock select, prescaler, capture and compare
// What this block does
// - two-bit clock source picks three sources or stop; stop keeps all state
// - external clock is synchronised; it must stay below a quarter of clk
// - selected clock drives a 7-bit prescaler chosen by three-bit field
// - one 16-bit counter shared by all channels, ticks on prescaled clock
// - up mode runs initial to modulo then reloads initial
// - up mode raises overflow when modulo returns to initial
// - initial bit 15 set makes comparisons signed, else unsigned
// - with extended features, zero modulo and initial hold counter at zero
// - center-align counts initial up to modulo then back down
// - up-down raises overflow stepping from modulo to modulo minus one
// - free-run 0 to FFFF in the two listed configurations
// - counter write or sync loads initial and resets non-compare outputs
// - overflow skip count N gives one flag per N+1 overflows; zero means every one
// - capture edge copies counter to channel value and sets channel flag
// - channel value writes are dropped while capturing
// - capture keeps working during debug halt with frozen counter
// - unfiltered capture flags on third clock after input edge
// - channels 0-3 filter at clk/4, restart on change, validate at value
// - filtered capture flags 1 to 4 plus 4 times filter value clocks later
// - compare match sets, clears or toggles output and sets flag
// - toggle mode holds prior output until first match
// - compare with edge select 0:0 flags but leaves output undriven
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "tcc_defs.svh"
module timer_counter_capture_compare #(
  parameter int NCH = 8,
  parameter int NFILT = 4
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire tcc_pkg::reg_req_t req,
  output logic [31:0]            rdata,
  input  wire logic              fixed_clk_in,
  input  wire logic              ext_clk_in,
  input  wire logic              debug_halt,
  input  wire logic [NCH-1:0]    ch_in,
  output logic [NCH-1:0]         ch_out,
  output logic [NCH-1:0]         ch_oe,
  output logic [NCH-1:0]         ch_irq,
  output logic                   overflow_irq
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]  prescale_select_r;
  logic [1:0]  clock_source_select_r;
  logic        center_align_select_r;
  logic        overflow_flag_r;
  logic        overflow_irq_enable_r;
  logic [4:0]  overflow_skip_count_r;
  logic [15:0] counter_value_r;
  logic [15:0] counter_modulo_r;
  logic [15:0] counter_initial_value_r;
  logic        extended_features_enable_r;
  logic        down_r;
  logic [4:0]  ovf_cnt_r;
  logic [6:0]  presc_r;
  ch_cfg_t     cfg_r [NCH];
  logic [15:0] channel_value_r [NCH];
  logic [3:0]  input_filter_value_r [NFILT];
  logic [NCH-1:0] sync1_r, sync2_r, edge_in_r;
  logic [NCH-1:0] out_r;

  wire logic wr_cnt = req.wr && req.addr == `ADDR_COUNTER_VALUE;
  wire logic sync_ev = req.wr && req.addr == `ADDR_MODE &&
                       req.wdata[`MODE_SYNC_BIT];
  wire logic cnt_reset = wr_cnt || sync_ev;

  // ----------------------------------------------------------------
  // clock source and prescaler
  // ----------------------------------------------------------------
  logic [2:0] fx_s_r, ex_s_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      fx_s_r <= 3'h0;
      ex_s_r <= 3'h0;
    end else begin
      fx_s_r <= {fx_s_r[1:0], fixed_clk_in};
      ex_s_r <= {ex_s_r[1:0], ext_clk_in};
    end
  end

  logic src_tick;
  always_comb begin
    case (clock_source_select_r)
      `CLOCK_SOURCE_SELECT_SYS:   src_tick = 1'b1;
      `CLOCK_SOURCE_SELECT_FIXED: src_tick = fx_s_r[1] && !fx_s_r[2];
      `CLOCK_SOURCE_SELECT_EXT:   src_tick = ex_s_r[1] && !ex_s_r[2];
      default:     src_tick = 1'b0;
    endcase
  end

  // prescaler divides by 2**prescale_select
  wire logic [6:0] presc_mask = 7'((8'h01 << prescale_select_r) - 8'h01);
  wire logic cnt_tick = src_tick && !debug_halt &&
                        ((presc_r & presc_mask) == presc_mask);

  always_ff @(posedge clk) begin
    if (srst || cnt_reset)
      presc_r <= 7'h00;
    else if (src_tick && !debug_halt)
      presc_r <= 7'((presc_r + 7'h01) & presc_mask);
  end

  // ----------------------------------------------------------------
  // main counter
  // ----------------------------------------------------------------
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b,
                               input logic sgn);
    sgt = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : sgt

  wire logic signed_mode = counter_initial_value_r[15];
  wire logic free_run =
    (!extended_features_enable_r &&
     (counter_modulo_r == `CNT_ZERO || counter_modulo_r == `FREE_MAX)) ||
    (extended_features_enable_r && !center_align_select_r &&
     counter_initial_value_r == `CNT_ZERO &&
     counter_modulo_r == `FREE_MAX);
  wire logic held_zero = extended_features_enable_r &&
    counter_modulo_r == `CNT_ZERO &&
    counter_initial_value_r == `CNT_ZERO;

  logic [15:0] cnt_nxt;
  logic        down_nxt;
  logic        ovf_ev;
  always_comb begin
    cnt_nxt = counter_value_r;
    down_nxt = down_r;
    ovf_ev = 1'b0;
    if (held_zero) begin
      cnt_nxt = `CNT_ZERO;
    end else if (free_run) begin
      cnt_nxt = counter_value_r + `CNT_ONE;
      ovf_ev = counter_value_r == `FREE_MAX;
    end else if (!center_align_select_r) begin
      if (counter_value_r == counter_modulo_r ||
          sgt(counter_value_r, counter_modulo_r, signed_mode)) begin
        cnt_nxt = counter_initial_value_r;
        ovf_ev = 1'b1;
      end else begin
        cnt_nxt = counter_value_r + `CNT_ONE;
      end
    end else begin
      if (!down_r) begin
        if (counter_value_r == counter_modulo_r) begin
          cnt_nxt = counter_value_r - `CNT_ONE;
          down_nxt = 1'b1;
          ovf_ev = 1'b1;
        end else begin
          cnt_nxt = counter_value_r + `CNT_ONE;
        end
      end else begin
        if (!sgt(counter_value_r, counter_initial_value_r, signed_mode))
          begin
          cnt_nxt = counter_value_r + `CNT_ONE;
          down_nxt = 1'b0;
        end else begin
          cnt_nxt = counter_value_r - `CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_value_r <= `CNT_ZERO;
      down_r <= 1'b0;
    end else if (cnt_reset) begin
      counter_value_r <= counter_initial_value_r;
      down_r <= 1'b0;
    end else if (cnt_tick) begin
      counter_value_r <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // overflow skip counter; software rewrites the counter after a change
  wire logic tof_set = cnt_tick && !cnt_reset && ovf_ev &&
                       ovf_cnt_r == overflow_skip_count_r;
  always_ff @(posedge clk) begin
    if (srst || cnt_reset)
      ovf_cnt_r <= 5'h00;
    else if (cnt_tick && ovf_ev)
      ovf_cnt_r <= tof_set ? 5'h00 : ovf_cnt_r + 5'h01;
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  wire logic wr_sc = req.wr && req.addr == `ADDR_STATUS_CONTROL;
  always_ff @(posedge clk) begin
    if (srst) begin
      prescale_select_r <= 3'h0;
      clock_source_select_r <= `CLOCK_SOURCE_SELECT_NONE;
      center_align_select_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
      overflow_skip_count_r <= 5'h00;
      counter_modulo_r <= `CNT_ZERO;
      counter_initial_value_r <= `CNT_ZERO;
      extended_features_enable_r <= 1'b0;
    end else if (req.wr) begin
      if (wr_sc) begin
        prescale_select_r <= req.wdata[`SC_PS_LSB +: 3];
        clock_source_select_r <= req.wdata[`SC_CLOCK_SOURCE_SELECT_LSB +: 2];
        center_align_select_r <= req.wdata[`SC_CENTER_ALIGN_SELECT_BIT];
        overflow_irq_enable_r <= req.wdata[6];
        overflow_skip_count_r <= req.wdata[`SC_OVERFLOW_SKIP_COUNT_LSB +: 5];
      end else if (req.addr == `ADDR_COUNTER_MODULO)
        counter_modulo_r <= req.wdata[15:0];
      else if (req.addr == `ADDR_COUNTER_INITIAL)
        counter_initial_value_r <= req.wdata[15:0];
      else if (req.addr == `ADDR_MODE)
        extended_features_enable_r <= req.wdata[`MODE_EXTENDED_FEATURES_ENABLE_BIT];
    end
  end

  // overflow flag: write 0 clears, a new overflow wins over the clear
  always_ff @(posedge clk) begin
    if (srst)
      overflow_flag_r <= 1'b0;
    else if (tof_set)
      overflow_flag_r <= 1'b1;
    else if (wr_sc && !req.wdata[`SC_TOF_BIT])
      overflow_flag_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= ch_in;
      sync2_r <= sync1_r;
    end
  end

  logic [NFILT-1:0] filt_r;
  logic [NCH-1:0]   det_in;
  logic [1:0]       fdiv_r;
  logic [3:0]       fcnt_r [NFILT];
  always_ff @(posedge clk) begin
    if (srst)
      fdiv_r <= 2'h0;
    else
      fdiv_r <= fdiv_r + 2'h1;
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire logic [15:0] my_wr_addr = 16'(`ADDR_CH_VALUE_BASE) + 16'(i);
    wire logic capture_mode = !center_align_select_r &&
      cfg_r[i].ms == 2'h0 && cfg_r[i].els != 2'h0;
    wire logic compare_mode = !center_align_select_r &&
      cfg_r[i].ms == 2'h1;
    wire logic edge_ev = (det_in[i] != edge_in_r[i]) &&
      ((det_in[i] && cfg_r[i].els[0]) ||
       (!det_in[i] && cfg_r[i].els[1]));
    wire logic match = compare_mode && cnt_tick &&
      cnt_nxt == channel_value_r[i] && !cnt_reset;
    wire logic wr_ctl = req.wr &&
      req.addr == 6'(`ADDR_CH_CTRL_BASE + i);
    wire logic cap = capture_mode && edge_ev;

    if (i < NFILT) begin : g_f
      // an unfiltered input skips the filter flop: three clocks in all
      assign det_in[i] = (input_filter_value_r[i] == 4'h0) ? sync2_r[i] :
                         filt_r[i];
      always_ff @(posedge clk) begin
        if (srst) begin
          fcnt_r[i] <= 4'h0;
          filt_r[i] <= 1'b0;
        end else if (input_filter_value_r[i] == 4'h0) begin
          fcnt_r[i] <= 4'h0;
          filt_r[i] <= sync2_r[i];
        end else if (sync2_r[i] == filt_r[i]) begin
          fcnt_r[i] <= 4'h0;
        end else if (fcnt_r[i] == input_filter_value_r[i]) begin
          filt_r[i] <= sync2_r[i];
          fcnt_r[i] <= 4'h0;
        end else if (fdiv_r == `FILT_DIV) begin
          fcnt_r[i] <= fcnt_r[i] + 4'h1;
        end
      end
    end else begin : g_nf
      assign det_in[i] = sync2_r[i];
    end

    always_ff @(posedge clk) begin
      if (srst)
        edge_in_r[i] <= 1'b0;
      else
        edge_in_r[i] <= det_in[i];
    end

    // capture also runs under debug halt, the counter is frozen then
    always_ff @(posedge clk) begin
      if (srst)
        channel_value_r[i] <= `CNT_ZERO;
      else if (cap)
        channel_value_r[i] <= counter_value_r;
      else if (req.wr && 16'(req.addr) == my_wr_addr && !capture_mode)
        channel_value_r[i] <= req.wdata[15:0];
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        cfg_r[i] <= '0;
      end else begin
        if (wr_ctl) begin
          cfg_r[i].els <= req.wdata[`CH_ELSB_BIT:`CH_ELSA_BIT];
          cfg_r[i].ms <= req.wdata[`CH_MSB_BIT:`CH_MSA_BIT];
          cfg_r[i].ie <= req.wdata[`CH_IE_BIT];
        end
        // set wins over a clear written in the same cycle
        if (cap || match)
          cfg_r[i].flag <= 1'b1;
        else if (wr_ctl && !req.wdata[`CH_FLAG_BIT])
          cfg_r[i].flag <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        out_r[i] <= 1'b0;
      end else if (cnt_reset && !compare_mode) begin
        out_r[i] <= 1'b0;
      end else if (match) begin
        case (cfg_r[i].els)
          2'h1: out_r[i] <= ~out_r[i];
          2'h2: out_r[i] <= 1'b0;
          2'h3: out_r[i] <= 1'b1;
          default: out_r[i] <= out_r[i];
        endcase
      end
    end

    assign ch_out[i] = out_r[i];
    assign ch_oe[i] = compare_mode && cfg_r[i].els != 2'h0;
    assign ch_irq[i] = cfg_r[i].flag && cfg_r[i].ie;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < NFILT; k++)
        input_filter_value_r[k] <= 4'h0;
    end else if (req.wr && req.addr == `ADDR_FILTER) begin
      for (int k = 0; k < NFILT; k++)
        input_filter_value_r[k] <= req.wdata[4*k +: 4];
    end
  end

  assign overflow_irq = overflow_flag_r && overflow_irq_enable_r;

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (!req.rd) begin
      rdata <= 32'h0000_0000;
    end else if (req.addr == `ADDR_STATUS_CONTROL) begin
      rdata <= {19'h0, overflow_skip_count_r, overflow_flag_r,
                overflow_irq_enable_r, center_align_select_r,
                clock_source_select_r, prescale_select_r};
    end else if (req.addr == `ADDR_COUNTER_VALUE) begin
      rdata <= {16'h0, counter_value_r};
    end else if (req.addr == `ADDR_COUNTER_MODULO) begin
      rdata <= {16'h0, counter_modulo_r};
    end else if (req.addr == `ADDR_COUNTER_INITIAL) begin
      rdata <= {16'h0, counter_initial_value_r};
    end else if (req.addr == `ADDR_MODE) begin
      rdata <= {31'h0, extended_features_enable_r};
    end else if (req.addr >= `ADDR_CH_CTRL_BASE &&
                 req.addr < 6'(`ADDR_CH_CTRL_BASE + NCH)) begin
      rdata <= {24'h0, cfg_r[req.addr[2:0]].flag,
                cfg_r[req.addr[2:0]].ie, cfg_r[req.addr[2:0]].ms,
                cfg_r[req.addr[2:0]].els, 2'h0};
    end else if (req.addr >= `ADDR_CH_VALUE_BASE &&
                 req.addr < 6'(`ADDR_CH_VALUE_BASE + NCH)) begin
      rdata <= {16'h0, channel_value_r[req.addr[2:0]]};
    end else if (req.addr == `ADDR_FILTER) begin
      rdata <= {16'h0, input_filter_value_r[3], input_filter_value_r[2],
                input_filter_value_r[1], input_filter_value_r[0]};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule : timer_counter_capture_compare

// File: dv/tcc_properties.sv
// port checker for the timer counter with capture and compare
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_properties #(
  parameter int NCH   = 8,
  parameter int NFILT = 4
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire tcc_pkg::reg_req_t req,
  input wire logic [31:0]       rdata,
  input wire logic              fixed_clk_in,
  input wire logic              ext_clk_in,
  input wire logic              debug_halt,
  input wire logic [NCH-1:0]    ch_in,
  input wire logic [NCH-1:0]    ch_out,
  input wire logic [NCH-1:0]    ch_oe,
  input wire logic [NCH-1:0]    ch_irq,
  input wire logic              overflow_irq
);
  import tcc_pkg::*;
  // ---------------------------------------------------------------
  // shadow of channel control, snooped from the register port
  // ---------------------------------------------------------------
  logic [1:0] ms0_r;
  logic [1:0] els0_r;
  logic       ie0_r;
  logic [1:0] ms7_r;
  logic       ca_r;
  // compare outputs are idle while center-aligned counting is on
  always_ff @(posedge clk) begin
    if (srst)
      ca_r <= 1'b0;
    else if (req.wr && req.addr == `ADDR_STATUS_CONTROL)
      ca_r <= req.wdata[`SC_CENTER_ALIGN_SELECT_BIT];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ms0_r  <= 2'h0;
      els0_r <= 2'h0;
      ie0_r  <= 1'b0;
    end else if (req.wr && req.addr == `ADDR_CH_CTRL_BASE) begin
      ms0_r  <= req.wdata[5:4];
      els0_r <= req.wdata[3:2];
      ie0_r  <= req.wdata[6];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ms7_r <= 2'h0;
    end else if (req.wr && req.addr == `ADDR_CH_CTRL_BASE + 6'h7) begin
      ms7_r <= req.wdata[5:4];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // input change three edges before the flag shows, two sync plus one
  sequence s_in_edge;
    $past(ch_in[7], 3) != $past(ch_in[7], 4);
  endsequence
  a_rdata_idle: assert property (!req.rd |=> rdata == 32'h0)
    else $error("read data not idle");
  a_unmapped_read: assert property (req.rd && req.addr == 6'h3F
    |=> rdata == 32'h0) else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(srst) |-> ch_out == '0
    && ch_oe == '0 && ch_irq == '0 && !overflow_irq)
    else $error("outputs not quiet after reset");
  a_oe_compare: assert property (ch_oe[0] ==
    (!ca_r && ms0_r == 2'h1 && els0_r != 2'h0))
    else $error("ch0 enable wrong");
  a_irq_level: assert property (ch_irq[0] |-> ie0_r)
    else $error("ch0 irq without enable");
  // a disabled output may only fall back to its idle level
  a_out_source: assert property ($changed(ch_out[0])
    |-> $past(ch_oe[0]) || !ch_out[0]) else $error("ch0 out moved");
  a_debug_freeze: assert property (debug_halt && !req.wr
    |=> $stable(ch_out)) else $error("outputs moved in halt");
  a_capture_delay: assert property ($rose(ch_irq[7])
    && ms7_r == 2'h0 && !$past(req.wr) |-> s_in_edge)
    else $error("capture flag latency wrong");
endmodule : tcc_properties

bind timer_counter_capture_compare tcc_properties #(
  .NCH   (NCH),
  .NFILT (NFILT)
) tcc_properties_i (
  .clk          (clk),
  .srst         (srst),
  .req          (req),
  .rdata        (rdata),
  .fixed_clk_in (fixed_clk_in),
  .ext_clk_in   (ext_clk_in),
  .debug_halt   (debug_halt),
  .ch_in        (ch_in),
  .ch_out       (ch_out),
  .ch_oe        (ch_oe),
  .ch_irq       (ch_irq),
  .overflow_irq (overflow_irq)
);

// File: dv/pin_source.sv
// far-side model: fixed and external counter clock sources
`timescale 1ns/1ps
module pin_source (
  input  wire logic clk,
  input  wire logic srst,
  output logic      fixed_clk_in,
  output logic      ext_clk_in
);
  logic [2:0] div_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  // fixed at clk/4, external at clk/8: both inside the sampling limits
  assign fixed_clk_in = div_r[1];
  assign ext_clk_in   = div_r[2];
endmodule : pin_source

// File: dv/tb.sv
// self-checking testbench for the timer counter
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tb;
  import tcc_pkg::*;
  logic        clk;
  logic        srst;
  reg_req_t    req;
  logic [31:0] rdata;
  logic        fixed_clk_in;
  logic        ext_clk_in;
  logic        debug_halt;
  logic [7:0]  ch_in;
  logic [7:0]  ch_out;
  logic [7:0]  ch_oe;
  logic [7:0]  ch_irq;
  logic        overflow_irq;
  int          n_errors;
  int          checked;
  int          cycles;
  always #2.5 clk = ~clk;
  pin_source pin_source_i (.clk(clk), .srst(srst),
    .fixed_clk_in(fixed_clk_in), .ext_clk_in(ext_clk_in));
  timer_counter_capture_compare timer_counter_capture_compare_i (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .fixed_clk_in(fixed_clk_in), .ext_clk_in(ext_clk_in),
    .debug_halt(debug_halt), .ch_in(ch_in), .ch_out(ch_out),
    .ch_oe(ch_oe), .ch_irq(ch_irq), .overflow_irq(overflow_irq));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  function automatic logic probe(input int s);
    case (s)
      0: return ch_out[0];
      1: return overflow_irq;
      2: return ch_irq[0];
      default: return ch_irq[7];
    endcase
  endfunction : probe
  // bounded wait; a hang shows up as a wrong count
  task automatic wait_edge(input int s, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (probe(s) !== lvl && n < 1000);
  endtask : wait_edge
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    for (int a = 0; a < 5; a++) begin
      rd(6'(a), d);
      check(d, 32'h0, "reset register");
    end
    rd(6'h3F, d);
    check(d, 32'h0, "unmapped read");
    wr(`ADDR_MODE, 32'h1);
    wr(`ADDR_STATUS_CONTROL, 32'h8);
    repeat (10) @(posedge clk);
    rd(`ADDR_COUNTER_VALUE, d);
    check(d[15:0], 16'h0, "held counter");
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_STATUS_CONTROL, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_stop_load();
    logic [31:0] c1;
    logic [31:0] c2;
    wr(`ADDR_COUNTER_INITIAL, 32'h2);
    wr(`ADDR_COUNTER_MODULO, 32'hFF);
    wr(`ADDR_COUNTER_VALUE, 32'h77);
    rd(`ADDR_COUNTER_VALUE, c1);
    check(c1[15:0], 16'h2, "counter load");
    wr(`ADDR_STATUS_CONTROL, 32'h8);
    repeat (30) @(posedge clk);
    wr(`ADDR_STATUS_CONTROL, 32'h0);
    rd(`ADDR_COUNTER_VALUE, c1);
    repeat (10) @(posedge clk);
    rd(`ADDR_COUNTER_VALUE, c2);
    check(c2, c1, "stopped counter");
    rd(`ADDR_COUNTER_MODULO, c2);
    check(c2[15:0], 16'hFF, "modulo kept");
    $display("test stop and load done");
  endtask : t_stop_load
  task automatic t_compare();
    int   ctl[4] = '{32'h5C, 32'h58, 32'h5C, 32'h54};
    logic exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic prev;
    int   n;
    prev = 1'b0;
    wr(`ADDR_COUNTER_INITIAL, 32'h0);
    wr(`ADDR_COUNTER_MODULO, 32'h4);
    wr(`ADDR_CH_VALUE_BASE, 32'h3);
    wr(`ADDR_COUNTER_VALUE, 32'h0);
    wr(`ADDR_STATUS_CONTROL, 32'h8);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CH_CTRL_BASE, 32'(ctl[i]));
      check(ch_out[0], prev, "out before match");
      wait_edge(2, 1'b1, n);
      check(ch_out[0], exp[i], "out at match");
      check(ch_oe[0], 1'b1, "out enable");
      prev = exp[i];
    end
    wr(`ADDR_CH_CTRL_BASE, 32'h50);
    check(ch_oe[0], 1'b0, "flag only enable");
    wait_edge(2, 1'b1, n);
    check(n < 6, 1'b1, "flag only match");
    wr(`ADDR_CH_CTRL_BASE, 32'h90);
    check(ch_irq[0], 1'b0, "irq masked");
    wr(`ADDR_CH_CTRL_BASE, 32'hD0);
    check(ch_irq[0], 1'b1, "irq unmasked");
    $display("test compare done");
  endtask : t_compare
  task automatic t_period();
    int ps[4]  = '{1, 0, 0, 3};
    int src[4] = '{1, 2, 3, 1};
    int exp[4] = '{10, 20, 40, 40};
    int n;
    wr(`ADDR_CH_CTRL_BASE, 32'h14);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_STATUS_CONTROL, 32'(ps[i] + src[i] * 8));
      wr(`ADDR_COUNTER_VALUE, 32'h0);
      wait_edge(0, !probe(0), n);
      wait_edge(0, !probe(0), n);
      check(n, exp[i], "toggle period");
    end
    // compare is off while center-aligned, so time the overflow flag
    wr(`ADDR_STATUS_CONTROL, 32'h68);
    wr(`ADDR_COUNTER_VALUE, 32'h0);
    wr(`ADDR_STATUS_CONTROL, 32'h68);
    wait_edge(1, 1'b1, n);
    wr(`ADDR_STATUS_CONTROL, 32'h68);
    wait_edge(1, 1'b1, n);
    check(n + 2, 8, "up-down period");
    $display("test period done");
  endtask : t_period
  task automatic t_overflow();
    int n;
    for (int skip = 0; skip < 3; skip += 2) begin
      wr(`ADDR_STATUS_CONTROL, 32'h48 + 32'(skip * 256));
      wr(`ADDR_COUNTER_VALUE, 32'h0);
      wr(`ADDR_STATUS_CONTROL, 32'h48 + 32'(skip * 256));
      wait_edge(1, 1'b1, n);
      wr(`ADDR_STATUS_CONTROL, 32'h48 + 32'(skip * 256));
      wait_edge(1, 1'b1, n);
      check(n + 2, 5 * (skip + 1), "overflow spacing");
    end
    wr(`ADDR_STATUS_CONTROL, 32'h8);
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_capture();
    logic [31:0] c;
    logic [31:0] d;
    int          n;
    wr(`ADDR_COUNTER_MODULO, 32'hFFFF);
    wr(`ADDR_COUNTER_VALUE, 32'h0);
    repeat (40) @(posedge clk);
    debug_halt <= 1'b1;
    rd(`ADDR_COUNTER_VALUE, c);
    for (int e = 1; e < 3; e++) begin
      wr(`ADDR_CH_CTRL_BASE + 6'h7, 32'(64 + e * 4));
      @(posedge clk);
      ch_in[7] <= (e == 1);
      wait_edge(3, 1'b1, n);
      check(n, 3, "capture latency");
      rd(`ADDR_CH_VALUE_BASE + 6'h7, d);
      check(d[15:0], c[15:0], "captured value");
      wr(`ADDR_CH_VALUE_BASE + 6'h7, 32'h1234);
      rd(`ADDR_CH_VALUE_BASE + 6'h7, d);
      check(d[15:0], c[15:0], "value write dropped");
    end
    @(posedge clk);
    debug_halt <= 1'b0;
    $display("test capture done");
  endtask : t_capture
  task automatic t_filter();
    int n;
    wr(`ADDR_FILTER, 32'h2);
    wr(`ADDR_CH_CTRL_BASE, 32'h44);
    @(posedge clk);
    ch_in[0] <= 1'b1;
    repeat (4) @(posedge clk);
    ch_in[0] <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check(ch_irq[0], 1'b0, "glitch dropped");
    @(posedge clk);
    ch_in[0] <= 1'b1;
    wait_edge(2, 1'b1, n);
    // divider runs free, so the figure has three clocks of slack
    check(n >= 9 && n <= 15, 1'b1, "filtered latency");
    $display("test filter done");
  endtask : t_filter
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    clk        = 1'b0;
    srst       = 1'b1;
    req        = '0;
    debug_halt = 1'b0;
    ch_in      = 8'h00;
    n_errors   = 0;
    checked    = 0;
    cycles     = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_stop_load();
    t_compare();
    t_period();
    t_overflow();
    t_capture();
    t_filter();
    give_verdict();
  end
endmodule : tb
